// ===== interprocessor_mailbox_flags_test.sv
`timescale 1ns/100ps
`default_nettype none
module interprocessor_mailbox_flags_test;
  logic mclk = 1'b0, rst_b = 1'b0;
  logic [7:0] awAddr = 8'h0, arAddr = 8'h0, dataReadyFlag;
  logic [31:0] wData = 32'h0, rData, expFlags = 32'h0;
  logic [3:0] wStrb = 4'hf;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, keyUnlocked, irq;
  logic [1:0] bResp, rResp;
  ipmbx_pkg::ipmbx_access_t txAccess, rxAccess;
  int errors = 0, n_compared = 0, cycles = 0;
  ipmbx_core_model core (.mclk(mclk), .txAccess(txAccess), .rxAccess(rxAccess));
  ipmbx_flags DUT (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .txAccess(txAccess), .rxAccess(rxAccess),
    .dataReadyFlag(dataReadyFlag), .keyUnlocked(keyUnlocked), .irq(irq));
  initial forever #50 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge mclk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    bReady <= 1'b0;
    check({30'h0, bResp}, {30'h0, er});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge mclk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    rReady <= 1'b0;
    check(rData, e);
    check({30'h0, rResp}, {30'h0, er});
  endtask
  task automatic flags(input logic [31:0] e);
    repeat (2) @(posedge mclk);
    check({24'h0, dataReadyFlag}, e);
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rc(ipmbx_pkg::ADDR_STATUS, 32'h0, ipmbx_pkg::RESP_OKAY);
    rc(ipmbx_pkg::ADDR_KEY, 32'h0, ipmbx_pkg::RESP_OKAY);
    core.send(3'h0);
    flags(32'h0);
    wc(ipmbx_pkg::ADDR_CTRL, 32'h1, ipmbx_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      core.send(3'(i));
      expFlags = {expFlags[30:0], 1'b1};
      flags(expFlags);
    end
    rc(ipmbx_pkg::ADDR_STATUS, 32'hff, ipmbx_pkg::RESP_OKAY);
    core.take(3'h3);
    flags(32'hf7);
    rc(ipmbx_pkg::ADDR_IRQ_STATUS, 32'h8ff, ipmbx_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    wc(ipmbx_pkg::ADDR_IRQ_MASK, 32'h800, ipmbx_pkg::RESP_OKAY);
    flags(32'hf7);
    check({31'h0, irq}, 32'h1);
    wc(ipmbx_pkg::ADDR_IRQ_STATUS, 32'h1ffff, ipmbx_pkg::RESP_OKAY);
    flags(32'hf7);
    check({31'h0, irq}, 32'h0);
    wc(ipmbx_pkg::ADDR_STATUS, 32'hffffff01, ipmbx_pkg::RESP_OKAY);
    rc(ipmbx_pkg::ADDR_STATUS, 32'hf6, ipmbx_pkg::RESP_OKAY);
    wc(ipmbx_pkg::ADDR_KEY, {24'h0, ipmbx_pkg::KEY_FIRST_DEFAULT}, ipmbx_pkg::RESP_OKAY);
    wc(ipmbx_pkg::ADDR_KEY, {24'h0, ipmbx_pkg::KEY_SECOND_DEFAULT}, ipmbx_pkg::RESP_OKAY);
    flags(32'hf6);
    check({31'h0, keyUnlocked}, 32'h1);
    rc(ipmbx_pkg::ADDR_KEY_STATUS, 32'h1, ipmbx_pkg::RESP_OKAY);
    wStrb <= 4'he;
    wc(ipmbx_pkg::ADDR_KEY, {24'h0, ipmbx_pkg::KEY_FIRST_DEFAULT}, ipmbx_pkg::RESP_OKAY);
    wStrb <= 4'hf;
    flags(32'hf6);
    check({31'h0, keyUnlocked}, 32'h1);
    rc(ipmbx_pkg::ADDR_KEY, 32'h0, ipmbx_pkg::RESP_OKAY);
    rc(8'h20, 32'h0, ipmbx_pkg::RESP_SLVERR);
    wc(8'h20, 32'h1, ipmbx_pkg::RESP_SLVERR);
    wc(ipmbx_pkg::ADDR_CTRL, 32'h0, ipmbx_pkg::RESP_OKAY);
    flags(32'h0);
    core.send(3'h1);
    flags(32'h0);
    stop_test();
  end
endmodule // interprocessor_mailbox_flags_test
bind ipmbx_flags ipmbx_flags_checker chk (.mclk(mclk), .rst_b(rst_b),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .txAccess(txAccess),
  .rxAccess(rxAccess), .dataReadyFlag(dataReadyFlag), .irq(irq));
`default_nettype wire

// ===== ipmbx_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module ipmbx_core_model (
  // Clock
  input wire logic mclk,
  // Mailbox strobes
  output var ipmbx_pkg::ipmbx_access_t txAccess,
  output var ipmbx_pkg::ipmbx_access_t rxAccess
);
  initial txAccess = '0;
  initial rxAccess = '0;
  // One-cycle strobe; idle index is scrambled so nothing stale is trusted
  task automatic send(input logic [2:0] i);
    @(posedge mclk);
    txAccess <= '{write: 1'b1, read: 1'b0, index: i};
    @(posedge mclk);
    txAccess <= '{write: 1'b0, read: 1'b0, index: ~i};
  endtask
  task automatic take(input logic [2:0] i);
    @(posedge mclk);
    rxAccess <= '{write: 1'b0, read: 1'b1, index: i};
    @(posedge mclk);
    rxAccess <= '{write: 1'b0, read: 1'b0, index: ~i};
  endtask
endmodule // ipmbx_core_model
`default_nettype wire

// ===== ipmbx_flags.sv
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - A transmitter write to a mailbox data word sets that mailbox's data-ready flag.
// - A flag reads zero when its mailbox is empty and while the handshake logic is disabled.
// - For the transmitter a set flag means the word is written and awaits the receiver.
// - For the receiver a set flag means a fresh word is waiting in that mailbox.
// - The status register holds eight flags A to H in its low byte, all zero after reset.
// - An 8-bit write-only key field is watched, each byte written while enabled compared to unlock values.
// - The upper byte of the key and status registers always reads as zero.
module ipmbx_flags #(
  parameter logic [7:0] KEY_FIRST = ipmbx_pkg::KEY_FIRST_DEFAULT,
  parameter logic [7:0] KEY_SECOND = ipmbx_pkg::KEY_SECOND_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mailbox data word accesses, same clock
  input wire ipmbx_pkg::ipmbx_access_t txAccess,
  input wire ipmbx_pkg::ipmbx_access_t rxAccess,
  // Flags seen by both cores, key state, interrupt
  output logic [7:0] dataReadyFlag,
  output logic keyUnlocked,
  output logic irq
);
  localparam int N = ipmbx_pkg::MBX_COUNT;

  logic [7:0] readyState;
  logic enable;
  logic [16:0] irqStatus;
  logic [16:0] irqMask;
  logic [7:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;
  logic wrFire;
  logic [N-1:0] setMask;
  logic [N-1:0] clrMask;
  logic keyWrite;
  logic unlockedWire;
  logic unlockPulse;
  logic [16:0] irqEvents;
  logic [N-1:0] swClr;
  logic [16:0] w1c;

  // Decoded one-hot index of an access that has the given kind
  function automatic logic [N-1:0] access_hot(input ipmbx_pkg::ipmbx_access_t a, input logic k);
    logic [N-1:0] hot;
    hot = '0;
    if (k) begin
      hot[a.index] = 1'b1;
    end
    return hot;
  endfunction

  // Write channel capture: address and data taken in either order
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ipmbx_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      case (awAddr[7:2])
        ipmbx_pkg::ADDR_KEY[7:2], ipmbx_pkg::ADDR_STATUS[7:2], ipmbx_pkg::ADDR_CTRL[7:2],
        ipmbx_pkg::ADDR_IRQ_STATUS[7:2], ipmbx_pkg::ADDR_IRQ_MASK[7:2],
        ipmbx_pkg::ADDR_KEY_STATUS[7:2]: begin
          s_axi_bresp <= ipmbx_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= ipmbx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Key byte lives in lane 0; only that lane's write is watched
  assign keyWrite = wrFire && (awAddr[7:2] == ipmbx_pkg::ADDR_KEY[7:2]) && wStrb[0];

  ipmbx_key_watch #(
    .FIRST(KEY_FIRST),
    .SECOND(KEY_SECOND)
  ) u_key (
    .mclk(mclk),
    .rst_b(rst_b),
    .keyWrite(keyWrite),
    .keyData(wData[7:0]),
    .unlocked(unlockedWire),
    .unlockPulse(unlockPulse),
    .relock(!enable)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      keyUnlocked <= 1'b0;
    end else begin
      keyUnlocked <= unlockedWire;
    end
  end

  // Control register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      enable <= ipmbx_pkg::CTRL_ENABLE_RESET;
    end else if (wrFire && awAddr[7:2] == ipmbx_pkg::ADDR_CTRL[7:2] && wStrb[0]) begin
      enable <= wData[ipmbx_pkg::CTRL_ENABLE_BIT];
    end
  end

  assign setMask = access_hot(txAccess, txAccess.write);
  assign clrMask = access_hot(rxAccess, rxAccess.read);

  // Software clear of flags by writing a one
  assign swClr = (wrFire && awAddr[7:2] == ipmbx_pkg::ADDR_STATUS[7:2] && wStrb[0]) ?
                 wData[N-1:0] : '0;

  // Flags: set beats clear; software may also clear by writing a one
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      readyState <= ipmbx_pkg::STATUS_RESET;
    end else if (!enable) begin
      readyState <= '0;
    end else begin
      readyState <= (readyState & ~(clrMask | swClr)) | setMask;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dataReadyFlag <= '0;
    end else begin
      dataReadyFlag <= enable ? ((readyState & ~(clrMask | swClr)) | setMask) : '0;
    end
  end

  // Interrupt status: flag set and flag clear events, plus unlock
  assign irqEvents = enable ? {unlockPulse, clrMask & readyState, setMask} : '0;

  assign w1c = (wrFire && awAddr[7:2] == ipmbx_pkg::ADDR_IRQ_STATUS[7:2]) ? wData[16:0] : '0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= (irqStatus & ~w1c) | irqEvents;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irqMask <= ipmbx_pkg::IRQ_MASK_RESET;
    end else if (wrFire && awAddr[7:2] == ipmbx_pkg::ADDR_IRQ_MASK[7:2]) begin
      irqMask <= wData[16:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // Read channel: one cycle to arready, data the edge after
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ipmbx_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ipmbx_pkg::RESP_OKAY;
        case (s_axi_araddr[7:2])
          ipmbx_pkg::ADDR_KEY[7:2]: begin
            s_axi_rdata <= 32'h00000000;
          end
          ipmbx_pkg::ADDR_STATUS[7:2]: begin
            s_axi_rdata <= {24'h000000, enable ? readyState : 8'h00};
          end
          ipmbx_pkg::ADDR_CTRL[7:2]: begin
            s_axi_rdata <= {31'h00000000, enable};
          end
          ipmbx_pkg::ADDR_IRQ_STATUS[7:2]: begin
            s_axi_rdata <= {15'h0000, irqStatus};
          end
          ipmbx_pkg::ADDR_IRQ_MASK[7:2]: begin
            s_axi_rdata <= {15'h0000, irqMask};
          end
          ipmbx_pkg::ADDR_KEY_STATUS[7:2]: begin
            s_axi_rdata <= {31'h00000000, unlockedWire};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ipmbx_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ipmbx_flags
`default_nettype wire

// ===== ipmbx_flags_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ipmbx_flags_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_wvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Mailbox side
  input wire ipmbx_pkg::ipmbx_access_t txAccess,
  input wire ipmbx_pkg::ipmbx_access_t rxAccess,
  input wire logic [7:0] dataReadyFlag,
  input wire logic irq
);
  logic [7:0] rdAddr;
  logic [1:0] quiet;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge mclk) begin
    if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
  end
  // Cycles since a receiver read or bus write, saturating
  always_ff @(posedge mclk) begin
    if (!rst_b || rxAccess.read || s_axi_wvalid) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  AST_SET: assert property (txAccess.write |=>
    dataReadyFlag[$past(txAccess.index)] || dataReadyFlag == 8'h00) else $error("flag not set");
  AST_CLR: assert property (rxAccess.read && !(txAccess.write &&
    txAccess.index == rxAccess.index) |=> !dataReadyFlag[$past(rxAccess.index)])
    else $error("flag not cleared");
  AST_RISE: assert property ((dataReadyFlag & ~$past(dataReadyFlag)) != 8'h00
    |-> $past(txAccess.write)) else $error("flag rose without a write");
  AST_FALL: assert property ((~dataReadyFlag & $past(dataReadyFlag)) != 8'h00
    |-> quiet != 2'h3) else $error("flag fell without a read");
  AST_RST: assert property ($rose(rst_b) |-> dataReadyFlag == 8'h00)
    else $error("flags not clear after reset");
  AST_KEYRD: assert property (s_axi_rvalid && rdAddr == ipmbx_pkg::ADDR_KEY
    |-> s_axi_rdata == 32'h0) else $error("key read not zero");
  AST_UPPER: assert property (s_axi_rvalid && rdAddr == ipmbx_pkg::ADDR_STATUS
    |-> s_axi_rdata[31:8] == 24'h0) else $error("status upper bits set");
  AST_MATCH: assert property ($rose(s_axi_rvalid) && rdAddr == ipmbx_pkg::ADDR_STATUS
    |-> s_axi_rdata[7:0] == $past(dataReadyFlag)) else $error("status differs from flags");
  cover property (txAccess.write);
  cover property (rxAccess.read);
  cover property ($rose(irq));
endmodule // ipmbx_flags_checker
`default_nettype wire

// ===== ipmbx_key_watch.sv
`timescale 1ns/100ps
`default_nettype none
module ipmbx_key_watch #(
  parameter logic [7:0] FIRST = ipmbx_pkg::KEY_FIRST_DEFAULT,
  parameter logic [7:0] SECOND = ipmbx_pkg::KEY_SECOND_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Key write strobe
  input wire logic keyWrite,
  input wire logic [7:0] keyData,
  // Unlock result
  output logic unlocked,
  output logic unlockPulse,
  input wire logic relock
);
  ipmbx_pkg::ipmbx_key_state_t state;
  ipmbx_pkg::ipmbx_key_state_t next_state;

  // Each key write is compared unless relock is high; any wrong byte restarts the sequence
  always_comb begin
    next_state = state;
    if (relock) begin
      next_state = ipmbx_pkg::KEY_IDLE;
    end else if (keyWrite) begin
      case (state)
        ipmbx_pkg::KEY_IDLE: begin
          next_state = (keyData == FIRST) ? ipmbx_pkg::KEY_FIRST : ipmbx_pkg::KEY_IDLE;
        end
        ipmbx_pkg::KEY_FIRST: begin
          next_state = (keyData == SECOND) ? ipmbx_pkg::KEY_OPEN :
                       (keyData == FIRST) ? ipmbx_pkg::KEY_FIRST : ipmbx_pkg::KEY_IDLE;
        end
        ipmbx_pkg::KEY_OPEN: begin
          next_state = (keyData == FIRST) ? ipmbx_pkg::KEY_FIRST : ipmbx_pkg::KEY_IDLE;
        end
        default: begin
          next_state = ipmbx_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= ipmbx_pkg::KEY_IDLE;
      unlockPulse <= 1'b0;
    end else begin
      state <= next_state;
      unlockPulse <= (next_state == ipmbx_pkg::KEY_OPEN) && (state != ipmbx_pkg::KEY_OPEN);
    end
  end

  assign unlocked = (state == ipmbx_pkg::KEY_OPEN);
endmodule // ipmbx_key_watch
`default_nettype wire

// ===== ipmbx_pkg.sv
package ipmbx_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_KEY = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_KEY_STATUS = 8'h14;
  // Field layout
  localparam int MBX_COUNT = 8;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int IRQ_SET_LSB = 0;
  localparam int IRQ_CLR_LSB = 8;
  localparam int IRQ_UNLOCK_BIT = 16;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic CTRL_ENABLE_RESET = 1'b0;
  localparam logic [16:0] IRQ_MASK_RESET = 17'h00000;
  // Key sequence defaults (arbitrary values)
  localparam logic [7:0] KEY_FIRST_DEFAULT = 8'h5a;
  localparam logic [7:0] KEY_SECOND_DEFAULT = 8'ha5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_FIRST = 2'b01,
    KEY_OPEN = 2'b10
  } ipmbx_key_state_t;

  // One mailbox access strobe from either core
  typedef struct packed {
    logic write;
    logic read;
    logic [2:0] index;
  } ipmbx_access_t;
endpackage : ipmbx_pkg
